// file: core/charge_request_defines.vh
// constants for the receiver-side request field encoder
// assumes includers want byte codes, field positions and register offsets
`ifndef CHARGE_REQUEST_DEFINES_VH
`define CHARGE_REQUEST_DEFINES_VH
// packet headers and request codes
`define HDR_SPECIFIC_REQUEST 8'h20
`define HDR_FOREIGN_OBJECT_STATUS 8'h22
`define HDR_RENEGOTIATE 8'h09
`define HDR_RX_POWER_24 8'h31
`define REQ_GUARANTEED_POWER 8'h01
`define REQ_RX_POWER_TYPE 8'h02
`define REQ_MOD_PARAMS 8'h03
`define REQ_MAXIMUM_POWER 8'h04
// field layout
`define POWER_FIELD_MASK 8'h3F
`define MOD_DEPTH_MASK 8'h03
`define MOD_POLARITY_BIT 2
`define FO_MODE_MASK 8'h03
`define FO_MODE_POWERED_OFF 2'h0
`define GUARANTEED_LIMIT 6'h1E
// kind selector written by software
`define KIND_GUARANTEED 3'h0
`define KIND_RX_TYPE 3'h1
`define KIND_MOD 3'h2
`define KIND_MAXIMUM 3'h3
`define KIND_FO_STATUS 3'h4
`define KIND_RENEGOTIATE 3'h5
// apb byte offsets
`define OFF_CONTROL 12'h000
`define OFF_POWER 12'h004
`define OFF_MOD 12'h008
`define OFF_QFACTOR 12'h00C
`define OFF_MESSAGE 12'h010
`define OFF_STATUS 12'h014
`endif

// file: core/charge_request_fields.v
// apb-programmed encoder for receiver request parameter and status messages
// assumes an apb master on clk_i; the frame sender reads header/bytes from outputs
`timescale 1ns/1ns
`default_nettype none
`include "charge_request_defines.vh"
module charge_request_fields (
    input wire clk_i,
    input wire reset_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    output reg [7:0] header_o,
    output reg [7:0] byte0_o,
    output reg [7:0] byte1_o,
    output reg [1:0] length_o,
    output reg over_limit_o
);
    reg rst_meta;
    reg rst_sync;
    reg [2:0] kind;
    reg [5:0] guaranteed;
    reg [5:0] maximum;
    reg [1:0] depth;
    reg polarity;
    reg [1:0] fo_mode;
    reg [7:0] qfactor;
    reg [7:0] next_header;
    reg [7:0] next_byte0;
    reg [7:0] next_byte1;
    reg [1:0] next_length;
    reg [31:0] next_rdata;
    reg next_err;
    wire setup;
    wire wr;

    assign setup = psel_i & ~penable_i;
    // a write lands only at the edge that completes the access phase
    assign wr = psel_i & penable_i & pready_o & pwrite_i;

    function known_offset;
        input [11:0] a;
        begin
            known_offset = (a == `OFF_CONTROL) || (a == `OFF_POWER) || (a == `OFF_MOD) ||
                (a == `OFF_QFACTOR) || (a == `OFF_MESSAGE) || (a == `OFF_STATUS);
        end
    endfunction

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // pready rises in the access cycle; the write is stored as it completes
    always @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            kind <= `KIND_GUARANTEED;
            guaranteed <= 6'h00;
            maximum <= 6'h00;
            depth <= 2'h0;
            polarity <= 1'b0;
            fo_mode <= `FO_MODE_POWERED_OFF;
            qfactor <= 8'h00;
        end else if (wr) begin
            if (paddr_i == `OFF_CONTROL) begin
                kind <= pwdata_i[2:0];
            end else if (paddr_i == `OFF_POWER) begin
                guaranteed <= pwdata_i[5:0];
                maximum <= pwdata_i[13:8];
            end else if (paddr_i == `OFF_MOD) begin
                depth <= pwdata_i[1:0];
                polarity <= pwdata_i[`MOD_POLARITY_BIT];
            end else if (paddr_i == `OFF_QFACTOR) begin
                qfactor <= pwdata_i[7:0];
                fo_mode <= pwdata_i[9:8];
            end
        end
    end

    always @* begin
        next_header = `HDR_SPECIFIC_REQUEST;
        next_byte0 = 8'h00;
        next_byte1 = 8'h00;
        next_length = 2'd2;
        case (kind)
            `KIND_GUARANTEED: begin
                next_byte0 = `REQ_GUARANTEED_POWER;
                next_byte1 = {2'b00, guaranteed};
            end
            `KIND_RX_TYPE: begin
                next_byte0 = `REQ_RX_POWER_TYPE;
                next_byte1 = `HDR_RX_POWER_24;
            end
            `KIND_MOD: begin
                next_byte0 = `REQ_MOD_PARAMS;
                next_byte1 = {5'b00000, polarity, depth};
            end
            `KIND_MAXIMUM: begin
                next_byte0 = `REQ_MAXIMUM_POWER;
                next_byte1 = {2'b00, maximum};
            end
            `KIND_FO_STATUS: begin
                next_header = `HDR_FOREIGN_OBJECT_STATUS;
                next_byte0 = {6'b000000, fo_mode};
                next_byte1 = qfactor;
            end
            default: begin
                // renegotiate and unused kinds fall back to the single zero byte
                next_header = `HDR_RENEGOTIATE;
                next_byte0 = 8'h00;
                next_length = 2'd1;
            end
        endcase
    end

    always @* begin
        next_rdata = 32'h0000_0000;
        next_err = ~known_offset(paddr_i);
        if (paddr_i == `OFF_CONTROL) begin
            next_rdata = {29'h0000_0000, kind};
        end else if (paddr_i == `OFF_POWER) begin
            next_rdata = {18'h0_0000, maximum, 2'b00, guaranteed};
        end else if (paddr_i == `OFF_MOD) begin
            next_rdata = {29'h0000_0000, polarity, depth};
        end else if (paddr_i == `OFF_QFACTOR) begin
            next_rdata = {22'h00_0000, fo_mode, qfactor};
        end else if (paddr_i == `OFF_MESSAGE) begin
            next_rdata = {6'h00, length_o, header_o, byte0_o, byte1_o};
        end else if (paddr_i == `OFF_STATUS) begin
            next_rdata = {31'h0000_0000, over_limit_o};
        end
    end

    always @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            header_o <= `HDR_SPECIFIC_REQUEST;
            byte0_o <= `REQ_GUARANTEED_POWER;
            byte1_o <= 8'h00;
            length_o <= 2'd2;
            over_limit_o <= 1'b0;
        end else begin
            pready_o <= setup;
            pslverr_o <= setup & next_err;
            if (setup && !pwrite_i) begin
                prdata_o <= next_rdata;
            end
            header_o <= next_header;
            byte0_o <= next_byte0;
            byte1_o <= next_byte1;
            length_o <= next_length;
            // flag only; the request is still encoded as software asked
            over_limit_o <= (guaranteed > `GUARANTEED_LIMIT);
        end
    end
endmodule
`default_nettype wire

// file: dv/charge_tx_decoder.sv
// transmitter-side field decoder fed by the encoder's message ports
// assumes header and bytes are settled registered values
`timescale 1ns/1ns
`default_nettype none
module charge_tx_decoder (
    input wire logic [7:0] header_i, input wire logic [7:0] byte0_i,
    input wire logic [7:0] byte1_i, output logic [2:0] fsk_o,
    output logic [5:0] scale_o, output logic mode_ok_o
);
    // reserved bits are masked off rather than faulted on
    assign fsk_o = byte1_i[2:0];
    assign scale_o = byte1_i[5:0];
    assign mode_ok_o = header_i == 8'h22 && byte0_i[1:0] == 2'h0;
endmodule
`default_nettype wire

// file: dv/charge_request_fields_sva.sv
// field relations on the encoder's message ports
// assumes it is bound into charge_request_fields
`timescale 1ns/1ns
`default_nettype none
module charge_request_fields_sva (
    input wire clk_i, input wire reset_n_i, input wire [7:0] header_o,
    input wire [7:0] byte0_o, input wire [7:0] byte1_o, input wire [1:0] length_o,
    input wire over_limit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire [15:0] hb = {header_o, byte0_o};
    chk_guar_resv: assert property (hb == 16'h2001 |-> byte1_o[7:6] == 2'h0)
        else $error("guaranteed reserved bits set");
    chk_guar_flag: assert property (hb == 16'h2001 |-> over_limit_o == (byte1_o > 8'h1E))
        else $error("over limit flag wrong");
    chk_rx_code: assert property (hb == 16'h2002 |-> byte1_o == 8'h31)
        else $error("packet type code wrong");
    chk_mod_resv: assert property (hb == 16'h2003 |-> byte1_o[7:3] == 5'h00)
        else $error("modulation reserved bits set");
    chk_max_resv: assert property (hb == 16'h2004 |-> byte1_o[7:6] == 2'h0)
        else $error("maximum reserved bits set");
    chk_spec_pair: assert property (header_o == 8'h20 |->
        length_o == 2'h2 && byte0_o inside {[8'h01:8'h04]})
        else $error("request pair wrong");
    chk_fo_mode: assert property (header_o == 8'h22 |->
        byte0_o[7:2] == 6'h00 && length_o == 2'h2)
        else $error("status mode byte wrong");
    chk_reneg_zero: assert property (header_o == 8'h09 |->
        {length_o, byte0_o, byte1_o} == 18'h1_0000)
        else $error("renegotiate not one zero byte");
    cover property (hb == 16'h2003);
    cover property (header_o == 8'h22);
    cover property (header_o == 8'h09);
endmodule
bind charge_request_fields charge_request_fields_sva u_sva (.clk_i, .reset_n_i,
    .header_o, .byte0_o, .byte1_o, .length_o, .over_limit_o);
`default_nettype wire

// file: dv/wireless_charge_request_fields_test.sv
// apb bench for the request encoder, decoder model on its outputs
// assumes design, decoder and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module wireless_charge_request_fields_test;
    logic clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, rd;
    logic pready_o, pslverr_o, over_limit_o, ok, err;
    logic [7:0] header_o, byte0_o, byte1_o;
    logic [1:0] length_o;
    logic [2:0] fsk;
    logic [5:0] sc;
    int mismatches = 0, checks = 0;
    always #5 clk_i = ~clk_i;
    charge_request_fields u_dut (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .header_o, .byte0_o,
        .byte1_o, .length_o, .over_limit_o);
    charge_tx_decoder u_tx (.header_i(header_o), .byte0_i(byte0_o), .byte1_i(byte1_o),
        .fsk_o(fsk), .scale_o(sc), .mode_ok_o(ok));
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task c(input logic [32:0] g, input logic [32:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task x(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge clk_i);
        penable_i <= 1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n == 20) mismatches++;
        {err, rd} = {pslverr_o, prdata_o};
        {psel_i, penable_i} <= 2'b00;
    endtask
    // message ports and the read-only message word must agree
    task m(input logic [31:0] e);
        @(posedge clk_i);
        @(negedge clk_i);
        c({length_o, header_o, byte0_o, byte1_o}, e);
        x(0, 12'h010, 0);
        c(rd, e);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1;
        repeat (3) @(posedge clk_i);
        m(32'h0220_0100);
        x(1, 12'h004, 32'hFFFF_EAFF);
        x(1, 12'h000, 0);
        m(32'h0220_013F);
        c(over_limit_o, 1);
        x(1, 12'h004, 32'h0000_2A1E);
        m(32'h0220_011E);
        c(over_limit_o, 0);
        x(1, 12'h000, 1);
        m(32'h0220_0231);
        x(1, 12'h008, 32'hFFFF_FFFF);
        x(1, 12'h000, 2);
        m(32'h0220_0307);
        c(fsk, 3'h7);
        x(1, 12'h008, 1);
        m(32'h0220_0301);
        c(fsk, 3'h1);
        x(1, 12'h000, 3);
        m(32'h0220_042A);
        c(sc, 6'h2A);
        x(1, 12'h00C, 32'h0000_03A5);
        x(1, 12'h000, 4);
        m(32'h0222_03A5);
        c(ok, 0);
        x(1, 12'h00C, 32'hFFFF_FCC3);
        m(32'h0222_00C3);
        c(ok, 1);
        x(1, 12'h000, 5);
        m(32'h0109_0000);
        x(1, 12'h000, 7);
        m(32'h0109_0000);
        x(0, 12'h020, 0);
        c({err, rd}, 33'h1_0000_0000);
        wrap_up;
    end
    initial begin
        #20000;
        mismatches++;
        wrap_up;
    end
endmodule
`default_nettype wire
